// ---- logic/avs_pkg.sv ----
// Purpose: Shared constants and types for the link switch control bank
// Assumes: 250 MHz system clock
// Notes: Register offsets are byte addresses on the two-wire port
package avs_pkg;
	// Register offsets
	localparam logic [7:0] REG_TERM = 8'h03;
	localparam logic [7:0] REG_AUX = 8'h04;
	localparam logic [7:0] REG_HP_WIDTH = 8'h05;
	localparam logic [7:0] REG_HP_OVR = 8'h06;
	localparam logic [7:0] REG_LOSS_CTL = 8'h07;
	localparam logic [7:0] REG_EDID_MODE = 8'h0e;
	localparam logic [7:0] REG_UNLOCK = 8'h0f;
	localparam logic [7:0] REG_LOSS_STAT = 8'h10;
	localparam logic [7:0] REG_VERSION = 8'hfe;
	localparam logic [7:0] REG_PART = 8'hff;
	// Reset values
	localparam logic [7:0] RST_TERM = 8'h0f;
	localparam logic [7:0] RST_AUX = 8'h07;
	localparam logic [7:0] RST_HP_WIDTH = 8'h05;
	localparam logic [7:0] RST_HP_OVR = 8'h00;
	localparam logic [7:0] RST_LOSS_CTL = 8'h00;
	localparam logic [7:0] RST_EDID_MODE = 8'h00;
	localparam logic [7:0] RST_UNLOCK = 8'h00;
	// Field positions and readback masks
	localparam int TERM_SRC_LSB = 4;
	localparam int AUX_DDC_BIT = 1;
	localparam int AUX_CEC_BIT = 0;
	localparam int HP_SRC_BIT = 4;
	localparam int LOSS_THR_LSB = 4;
	localparam int LOSS_SQ_BIT = 2;
	localparam int LOSS_EN_BIT = 0;
	localparam int EDID_BYPASS_BIT = 0;
	localparam logic [7:0] AUX_MASK = 8'h07;
	localparam logic [7:0] HP_OVR_MASK = 8'h1f;
	localparam logic [7:0] LOSS_CTL_MASK = 8'h37;
	// Field codes
	localparam logic [3:0] TERM_SRC_MANUAL = 4'hf;
	localparam logic [7:0] UNLOCK_KEY = 8'h96;
	localparam logic [4:0] SLAVE_ADDR_HI = 5'h12;
	// Hot-plug pulse step
	localparam int HP_STEP_MS = 24;
	localparam int CLK_KHZ = 250_000;
	localparam int HP_STEP_CYCLES = HP_STEP_MS * CLK_KHZ;
	// Two-wire slave states
	typedef enum logic [3:0] {
		ST_IDLE, ST_DEV, ST_DEV_ACK, ST_REG, ST_REG_ACK,
		ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_WAIT
	} avs_i2c_state_t;
endpackage : avs_pkg

// ---- logic/avs_hp_if.sv ----
// Purpose: Carries hot-plug control between register bank and driver
// Assumes: One clock domain
// Notes: Driver owns low_oe and busy
`timescale 1ns/1ps
`default_nettype none
interface avs_hp_if;
	logic [7:0] pulse_length;
	logic source_manual;
	logic [3:0] manual_levels;
	logic trigger;
	logic [3:0] low_oe;
	logic busy;
	modport ctrl (output pulse_length, output source_manual, output manual_levels, output trigger,
		input low_oe, input busy);
	modport drv (input pulse_length, input source_manual, input manual_levels, input trigger,
		output low_oe, output busy);
endinterface : avs_hp_if
`default_nettype wire

// ---- logic/avs_hotplug_drv.sv ----
// Purpose: Hot-plug pin driver, timed pulse or direct manual levels
// Assumes: Trigger is a one-cycle pulse on the system clock
// Notes: A new trigger restarts a running pulse
`timescale 1ns/1ps
`default_nettype none
module avs_hotplug_drv #(
	parameter int STEP_CYCLES = avs_pkg::HP_STEP_CYCLES
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	// Control and pin enables
	avs_hp_if.drv hp
);
	logic [31:0] step_cnt_r;
	logic [7:0] steps_left_r;
	logic busy_r;
	logic [3:0] low_oe_r;

	generate
		if (STEP_CYCLES < 1) begin : g_bad_step
			$error("STEP_CYCLES must be at least one");
		end
	endgenerate

	// Step timer
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			busy_r <= 1'b0;
			steps_left_r <= 8'h00;
			step_cnt_r <= 32'h0;
		end else if (hp.source_manual) begin
			busy_r <= 1'b0;
			steps_left_r <= 8'h00;
		end else if (hp.trigger && hp.pulse_length != 8'h00) begin
			busy_r <= 1'b1;
			steps_left_r <= hp.pulse_length;
			step_cnt_r <= 32'(STEP_CYCLES - 1);
		end else if (busy_r) begin
			if (step_cnt_r == 32'h0) begin
				step_cnt_r <= 32'(STEP_CYCLES - 1);
				if (steps_left_r == 8'h01) begin
					busy_r <= 1'b0;
				end
				steps_left_r <= steps_left_r - 8'h01;
			end else begin
				step_cnt_r <= step_cnt_r - 32'h1;
			end
		end
	end

	// Pin enables
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			low_oe_r <= 4'h0;
		end else if (hp.source_manual) begin
			low_oe_r <= hp.manual_levels;
		end else begin
			low_oe_r <= {4{busy_r}};
		end
	end

	assign hp.low_oe = low_oe_r;
	assign hp.busy = busy_r;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_pulse_start;
		!hp.source_manual && hp.trigger && hp.pulse_length != 8'h00;
	endsequence

	sequence s_pulse_armed;
		busy_r && steps_left_r == $past(hp.pulse_length) ##1 (low_oe_r == 4'hf || hp.source_manual);
	endsequence

	a_pulse_start: assert property (s_pulse_start |=> s_pulse_armed)
		else $error("Hot-plug pulse did not start");
	a_pulse_end: assert property ($fell(busy_r) && !hp.source_manual |->
		$past(steps_left_r) == 8'h01 && $past(step_cnt_r) == 32'h0)
		else $error("Hot-plug pulse ended early");
	a_manual_levels: assert property (hp.source_manual |=> low_oe_r == $past(hp.manual_levels))
		else $error("Manual hot-plug level wrong");
	a_auto_idle: assert property (!hp.source_manual && !busy_r |=> low_oe_r == 4'h0)
		else $error("Hot-plug driven while idle");
endmodule : avs_hotplug_drv
`default_nettype wire

// ---- logic/avs_ctrl_regs.sv ----
// Purpose: Control and status bank of a four-input link switch, two-wire slave port
// Assumes: Pins pass a three-stage synchroniser; channel switch and active input are local
// Notes: Register pointer advances after each data byte
// Function
// - Source field zero automatic, all ones manual
// - Manual: one-hot bits enable input terminations
// - Manual selection zero switches all terminations off
// - Aux bit 1 enables display channel buffer
// - Aux bit 0 enables consumer control buffer
// - Pulse lasts width times 24 ms step
// - Override bit 4 clear: automatic pulsing
// - Override bit 4 set: manual field drives outputs
// - Manual set bits drive low, zero releases
// - Loss control bit 2 enables auto squelch
// - Loss bit 0 enables detection, threshold bits
// - Mode bit 0 bypasses replicator for SRAM writes
// - EEPROM writes allowed only with key 0x96
// - Status shows one signal loss bit per input, any number set at once
`timescale 1ns/1ps
`default_nettype none
module avs_ctrl_regs #(
	parameter int HP_STEP_CYCLES = avs_pkg::HP_STEP_CYCLES,
	parameter logic [7:0] SILICON_VERSION = 8'h5a, // Arbitrary value
	parameter logic [7:0] PART_CODE = 8'h3c // Arbitrary value
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	// Two-wire slave pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic [1:0] i_addr_strap,
	// Local switch state
	input wire logic i_channel_switch,
	input wire logic [1:0] i_active_input,
	input wire logic [3:0] i_signal_lost,
	// Termination and buffers
	output logic [3:0] o_termination_on,
	output logic o_display_channel_buffer_on,
	output logic o_consumer_control_buffer_on,
	// Hot-plug pins
	output logic [3:0] o_hotplug_out,
	output logic [3:0] o_hotplug_out_oe,
	// Signal loss and replicator
	output logic o_signal_loss_detect_on,
	output logic [1:0] o_signal_loss_threshold,
	output logic o_auto_squelch_on,
	output logic [3:0] o_signal_loss_flags,
	output logic o_replicator_bypass,
	output logic o_eeprom_write_allowed
);
	localparam int NPIN = 8;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_f_r;
	logic scl_prev_r;
	logic sda_prev_r;
	logic scl_f;
	logic sda_f;
	logic [1:0] strap_f;
	logic [3:0] lost_f;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	avs_pkg::avs_i2c_state_t state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] ptr_r;
	logic is_read_r;
	logic mack_r;
	logic sda_oe_r;
	logic wr_stb_r;
	logic [7:0] wr_addr_r;
	logic [7:0] wr_data_r;
	logic [7:0] rd_data;
	logic [7:0] term_r;
	logic [7:0] aux_r;
	logic [7:0] hp_width_r;
	logic [7:0] hp_ovr_r;
	logic [7:0] loss_ctl_r;
	logic [7:0] edid_mode_r;
	logic [7:0] unlock_r;
	logic [3:0] term_on_r;
	logic ddc_on_r;
	logic cec_on_r;
	logic detect_on_r;
	logic [1:0] thr_r;
	logic squelch_r;
	logic [3:0] flags_r;
	logic bypass_r;
	logic allowed_r;
	logic sda_out_r;
	logic [3:0] hp_level_r;

	avs_hp_if hp ();

	assign pin_raw = {i_signal_lost, i_addr_strap, i_sda, i_scl};

	// Three-stage synchroniser and agreement filter per pin
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			logic [2:0] sync_r;
			always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					sync_r <= 3'h7;
					pin_f_r[gi] <= 1'b1;
				end else begin
					sync_r <= {sync_r[1:0], pin_raw[gi]};
					if (sync_r[1] == sync_r[2]) begin
						pin_f_r[gi] <= sync_r[2];
					end
				end
			end
		end
	endgenerate

	assign scl_f = pin_f_r[0];
	assign sda_f = pin_f_r[1];
	assign strap_f = pin_f_r[3:2];
	assign lost_f = pin_f_r[7:4];

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_prev_r <= scl_f;
			sda_prev_r <= sda_f;
		end
	end

	assign scl_rise = scl_f & ~scl_prev_r;
	assign scl_fall = ~scl_f & scl_prev_r;
	assign bus_start = scl_f & scl_prev_r & sda_prev_r & ~sda_f;
	assign bus_stop = scl_f & scl_prev_r & ~sda_prev_r & sda_f;

	// Readback mux
	always_comb begin
		if (ptr_r == avs_pkg::REG_TERM) begin
			rd_data = term_r;
		end else if (ptr_r == avs_pkg::REG_AUX) begin
			rd_data = aux_r;
		end else if (ptr_r == avs_pkg::REG_HP_WIDTH) begin
			rd_data = hp_width_r;
		end else if (ptr_r == avs_pkg::REG_HP_OVR) begin
			rd_data = hp_ovr_r;
		end else if (ptr_r == avs_pkg::REG_LOSS_CTL) begin
			rd_data = loss_ctl_r;
		end else if (ptr_r == avs_pkg::REG_LOSS_STAT) begin
			rd_data = {4'h0, flags_r};
		end else if (ptr_r == avs_pkg::REG_VERSION) begin
			rd_data = SILICON_VERSION;
		end else if (ptr_r == avs_pkg::REG_PART) begin
			rd_data = PART_CODE;
		end else begin
			rd_data = 8'h00;
		end
	end

	// Two-wire slave sequencer
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= avs_pkg::ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ptr_r <= 8'h00;
			is_read_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe_r <= 1'b0;
			wr_stb_r <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 8'h00;
		end else begin
			wr_stb_r <= 1'b0;
			if (bus_stop) begin
				state_r <= avs_pkg::ST_IDLE;
				sda_oe_r <= 1'b0;
			end else if (bus_start) begin
				state_r <= avs_pkg::ST_DEV;
				bit_cnt_r <= 4'h0;
				sda_oe_r <= 1'b0;
			end else begin
				case (state_r)
					avs_pkg::ST_DEV, avs_pkg::ST_REG, avs_pkg::ST_WR: begin
						if (scl_rise) begin
							shift_r <= {shift_r[6:0], sda_f};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end else if (scl_fall && bit_cnt_r == 4'h8) begin
							bit_cnt_r <= 4'h0;
							if (state_r == avs_pkg::ST_DEV) begin
								if (shift_r[7:1] == {avs_pkg::SLAVE_ADDR_HI, strap_f}) begin
									sda_oe_r <= 1'b1;
									is_read_r <= shift_r[0];
									state_r <= avs_pkg::ST_DEV_ACK;
								end else begin
									state_r <= avs_pkg::ST_WAIT;
								end
							end else if (state_r == avs_pkg::ST_REG) begin
								ptr_r <= shift_r;
								sda_oe_r <= 1'b1;
								state_r <= avs_pkg::ST_REG_ACK;
							end else begin
								wr_stb_r <= 1'b1;
								wr_addr_r <= ptr_r;
								wr_data_r <= shift_r;
								ptr_r <= ptr_r + 8'h01;
								sda_oe_r <= 1'b1;
								state_r <= avs_pkg::ST_WR_ACK;
							end
						end
					end
					avs_pkg::ST_DEV_ACK: begin
						if (scl_fall) begin
							if (is_read_r) begin
								shift_r <= rd_data;
								sda_oe_r <= ~rd_data[7];
								bit_cnt_r <= 4'h1;
								state_r <= avs_pkg::ST_RD;
							end else begin
								sda_oe_r <= 1'b0;
								state_r <= avs_pkg::ST_REG;
							end
						end
					end
					avs_pkg::ST_REG_ACK, avs_pkg::ST_WR_ACK: begin
						if (scl_fall) begin
							sda_oe_r <= 1'b0;
							state_r <= avs_pkg::ST_WR;
						end
					end
					avs_pkg::ST_RD: begin
						if (scl_fall) begin
							if (bit_cnt_r == 4'h8) begin
								sda_oe_r <= 1'b0;
								bit_cnt_r <= 4'h0;
								ptr_r <= ptr_r + 8'h01;
								state_r <= avs_pkg::ST_RD_ACK;
							end else begin
								sda_oe_r <= ~shift_r[6];
								shift_r <= {shift_r[6:0], 1'b0};
								bit_cnt_r <= bit_cnt_r + 4'h1;
							end
						end
					end
					avs_pkg::ST_RD_ACK: begin
						if (scl_rise) begin
							mack_r <= ~sda_f;
						end else if (scl_fall) begin
							if (mack_r) begin
								shift_r <= rd_data;
								sda_oe_r <= ~rd_data[7];
								bit_cnt_r <= 4'h1;
								state_r <= avs_pkg::ST_RD;
							end else begin
								state_r <= avs_pkg::ST_WAIT;
							end
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Register writes; unmapped and read-only offsets ignore writes
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			term_r <= avs_pkg::RST_TERM;
			aux_r <= avs_pkg::RST_AUX;
			hp_width_r <= avs_pkg::RST_HP_WIDTH;
			hp_ovr_r <= avs_pkg::RST_HP_OVR;
			loss_ctl_r <= avs_pkg::RST_LOSS_CTL;
			edid_mode_r <= avs_pkg::RST_EDID_MODE;
			unlock_r <= avs_pkg::RST_UNLOCK;
		end else if (wr_stb_r) begin
			if (wr_addr_r == avs_pkg::REG_TERM) begin
				term_r <= wr_data_r;
			end else if (wr_addr_r == avs_pkg::REG_AUX) begin
				aux_r <= wr_data_r & avs_pkg::AUX_MASK;
			end else if (wr_addr_r == avs_pkg::REG_HP_WIDTH) begin
				hp_width_r <= wr_data_r;
			end else if (wr_addr_r == avs_pkg::REG_HP_OVR) begin
				hp_ovr_r <= wr_data_r & avs_pkg::HP_OVR_MASK;
			end else if (wr_addr_r == avs_pkg::REG_LOSS_CTL) begin
				loss_ctl_r <= wr_data_r & avs_pkg::LOSS_CTL_MASK;
			end else if (wr_addr_r == avs_pkg::REG_EDID_MODE) begin
				edid_mode_r <= wr_data_r;
			end else if (wr_addr_r == avs_pkg::REG_UNLOCK) begin
				unlock_r <= wr_data_r;
			end
		end
	end

	// Registered control outputs
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			term_on_r <= 4'h0;
			ddc_on_r <= 1'b0;
			cec_on_r <= 1'b0;
			detect_on_r <= 1'b0;
			thr_r <= 2'h0;
			squelch_r <= 1'b0;
			flags_r <= 4'h0;
			bypass_r <= 1'b0;
			allowed_r <= 1'b0;
			sda_out_r <= 1'b0;
			hp_level_r <= 4'h0;
		end else begin
			if (term_r[7:avs_pkg::TERM_SRC_LSB] == avs_pkg::TERM_SRC_MANUAL) begin
				term_on_r <= term_r[3:0];
			end else begin
				term_on_r <= 4'h1 << i_active_input;
			end
			ddc_on_r <= aux_r[avs_pkg::AUX_DDC_BIT];
			cec_on_r <= aux_r[avs_pkg::AUX_CEC_BIT];
			detect_on_r <= loss_ctl_r[avs_pkg::LOSS_EN_BIT];
			thr_r <= loss_ctl_r[avs_pkg::LOSS_THR_LSB +: 2];
			squelch_r <= loss_ctl_r[avs_pkg::LOSS_SQ_BIT];
			flags_r <= loss_ctl_r[avs_pkg::LOSS_EN_BIT] ? lost_f : 4'h0;
			bypass_r <= edid_mode_r[avs_pkg::EDID_BYPASS_BIT];
			allowed_r <= unlock_r == avs_pkg::UNLOCK_KEY;
			sda_out_r <= 1'b0;
			hp_level_r <= 4'h0;
		end
	end

	// Hot-plug driver
	assign hp.pulse_length = hp_width_r;
	assign hp.source_manual = hp_ovr_r[avs_pkg::HP_SRC_BIT];
	assign hp.manual_levels = hp_ovr_r[3:0];
	assign hp.trigger = i_channel_switch;

	avs_hotplug_drv #(
		.STEP_CYCLES(HP_STEP_CYCLES)
	) u_hotplug (
		.i_sys_clk(i_sys_clk),
		.i_arst_n(i_arst_n),
		.hp(hp)
	);

	assign o_sda = sda_out_r;
	assign o_sda_oe = sda_oe_r;
	assign o_termination_on = term_on_r;
	assign o_display_channel_buffer_on = ddc_on_r;
	assign o_consumer_control_buffer_on = cec_on_r;
	assign o_hotplug_out = hp_level_r;
	assign o_hotplug_out_oe = hp.low_oe;
	assign o_signal_loss_detect_on = detect_on_r;
	assign o_signal_loss_threshold = thr_r;
	assign o_auto_squelch_on = squelch_r;
	assign o_signal_loss_flags = flags_r;
	assign o_replicator_bypass = bypass_r;
	assign o_eeprom_write_allowed = allowed_r;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);

	a_term_auto: assert property (i_arst_n && term_r[7:4] != 4'hf |=>
		term_on_r == (4'h1 << $past(i_active_input)))
		else $error("Automatic termination wrong");
	a_term_manual: assert property (term_r[7:4] == 4'hf |=> term_on_r == $past(term_r[3:0]))
		else $error("Manual termination wrong");
	a_term_off: assert property (term_r == 8'hf0 [*2] |-> term_on_r == 4'h0)
		else $error("Terminations not off");
	a_ddc_buffer: assert property (wr_stb_r && wr_addr_r == 8'h04 |-> ##2 ddc_on_r == $past(wr_data_r[1], 2))
		else $error("Display buffer enable wrong");
	a_cec_buffer: assert property (wr_stb_r && wr_addr_r == 8'h04 |-> ##2 cec_on_r == $past(wr_data_r[0], 2))
		else $error("Control buffer enable wrong");
	a_squelch_bit: assert property (##1 squelch_r == $past(loss_ctl_r[2]))
		else $error("Squelch enable wrong");
	a_detect_gate: assert property (!loss_ctl_r[0] |=> flags_r == 4'h0 && !detect_on_r)
		else $error("Loss flags while detect off");
	a_bypass_bit: assert property (##1 bypass_r == $past(edid_mode_r[0]))
		else $error("Replicator bypass wrong");
	a_unlock_key: assert property (wr_stb_r && wr_addr_r == 8'h0f |-> ##2 allowed_r == ($past(wr_data_r, 2) == 8'h96))
		else $error("Write unlock wrong");
	a_loss_flags: assert property (loss_ctl_r[0] |=> flags_r == $past(lost_f))
		else $error("Loss flags wrong");
	a_ack_addr: assert property (state_r == avs_pkg::ST_DEV && scl_fall && bit_cnt_r == 4'h8 &&
		shift_r[7:1] == {5'h12, strap_f} && !bus_start && !bus_stop |=> sda_oe_r)
		else $error("Own address not acknowledged");
endmodule : avs_ctrl_regs
`default_nettype wire

// ---- verification/avs_i2c_host_model.sv ----
// Purpose: Two-wire bus master model driving the control bank port
// Assumes: Open-drain data line with pull-up, resolved by the bench
// Notes: Phases of 16 clocks keep well above the 8-clock minimum
`timescale 1ns/1ps
`default_nettype none
module avs_i2c_host_model (
	// Clock
	input wire logic i_clk,
	// Bus lines
	input wire logic i_sda_line,
	output logic o_scl,
	output logic o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick

	// Start or repeated start
	task automatic start_cond();
		o_sda_low <= 1'b0;
		tick(8);
		o_scl <= 1'b1;
		tick(16);
		o_sda_low <= 1'b1;
		tick(16);
		o_scl <= 1'b0;
		tick(8);
	endtask : start_cond

	task automatic stop_cond();
		o_sda_low <= 1'b1;
		tick(8);
		o_scl <= 1'b1;
		tick(16);
		o_sda_low <= 1'b0;
		tick(16);
	endtask : stop_cond

	// Data set mid-low, sampled mid-high
	task automatic put_bit(input logic b, output logic seen);
		o_sda_low <= ~b;
		tick(8);
		o_scl <= 1'b1;
		tick(8);
		seen = i_sda_line;
		tick(8);
		o_scl <= 1'b0;
		tick(8);
	endtask : put_bit

	task automatic put_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) put_bit(v[i], s);
		put_bit(1'b1, s);
		ack = ~s;
	endtask : put_byte

	task automatic get_byte(input logic last, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, s);
			v[i] = s;
		end
		put_bit(last, s);
	endtask : get_byte

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start_cond();
		put_byte({dev, 1'b0}, a0);
		put_byte(ra, a1);
		put_byte(d, a2);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : write_reg

	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start_cond();
		put_byte({dev, 1'b0}, a0);
		put_byte(ra, a1);
		start_cond();
		put_byte({dev, 1'b1}, a2);
		get_byte(1'b1, d);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : read_reg
endmodule : avs_i2c_host_model
`default_nettype wire

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for the link switch control bank
// Assumes: Short hot-plug step for simulation
// Notes: All register access goes over the two-wire port
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int STEP = 10;
	localparam logic [7:0] VER = 8'ha7; // Arbitrary value
	localparam logic [7:0] PART = 8'h4e; // Arbitrary value
	localparam int CEIL = 90000;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic scl, sda_low, sda_oe, chsw, ddc, cec, det, sq, bypass, unlock;
	logic sda_lvl;
	logic [1:0] act, thr, strap;
	logic [3:0] lost, term, hp_oe, flags, hp_lvl;
	logic [6:0] dev_addr;
	logic [7:0] rdat;
	logic ok;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	int cnt;
	logic [7:0] def_addr [0:9] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0e, 8'h0f, 8'h10, 8'hfe, 8'hff};
	logic [7:0] def_val [0:9] = '{8'h0f, 8'h07, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, VER, PART};
	logic [3:0] oh_tab [0:5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
	logic [7:0] keys [0:3] = '{8'h96, 8'h95, 8'h96, 8'h00};
	wire logic sda_line = ~(sda_low | sda_oe);

	assign dev_addr = {avs_pkg::SLAVE_ADDR_HI, strap};
	always #2 sys_clk = ~sys_clk;

	avs_i2c_host_model m (.i_clk(sys_clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda_low(sda_low));

	avs_ctrl_regs #(.HP_STEP_CYCLES(STEP), .SILICON_VERSION(VER), .PART_CODE(PART)) dut (
		.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda_line), .o_sda(sda_lvl),
		.o_sda_oe(sda_oe), .i_addr_strap(strap), .i_channel_switch(chsw), .i_active_input(act),
		.i_signal_lost(lost), .o_termination_on(term), .o_display_channel_buffer_on(ddc),
		.o_consumer_control_buffer_on(cec), .o_hotplug_out(hp_lvl), .o_hotplug_out_oe(hp_oe),
		.o_signal_loss_detect_on(det), .o_signal_loss_threshold(thr), .o_auto_squelch_on(sq),
		.o_signal_loss_flags(flags), .o_replicator_bypass(bypass), .o_eeprom_write_allowed(unlock)
	);

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] ra, input logic [7:0] d);
		m.write_reg(dev_addr, ra, d, ok);
		chk("write ack", 8'h01, {7'h0, ok});
		repeat (8) @(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
		m.read_reg(dev_addr, ra, rdat, ok);
		chk("read ack", 8'h01, {7'h0, ok});
		chk("read data", exp, rdat);
	endtask : rd

	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == CEIL) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		chsw <= 1'b0;
		act <= 2'd2;
		lost <= 4'h0;
		strap <= 2'b01;
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk("auto termination", 8'h04, {4'h0, term});
		chk("aux buffers", 8'h03, {6'h0, ddc, cec});
		for (int i = 0; i < 10; i++) rd(def_addr[i], def_val[i]);
		for (int i = 0; i < 6; i++) begin
			wr(avs_pkg::REG_TERM, {4'hf, oh_tab[i]});
			chk("manual termination", {4'h0, oh_tab[i]}, {4'h0, term});
		end
		wr(avs_pkg::REG_TERM, 8'h00);
		for (int a = 0; a < 4; a++) begin
			act <= a[1:0];
			repeat (4) @(posedge sys_clk);
			chk("auto termination", 8'h01 << a, {4'h0, term});
		end
		for (int v = 0; v < 4; v++) begin
			wr(avs_pkg::REG_AUX, {6'h01, v[1:0]});
			chk("aux buffers", {6'h0, v[1:0]}, {6'h0, ddc, cec});
			rd(avs_pkg::REG_AUX, {6'h01, v[1:0]});
		end
		lost <= 4'h5;
		wr(avs_pkg::REG_LOSS_CTL, 8'h00);
		chk("flags while off", 8'h00, {4'h0, flags});
		for (int t = 0; t < 4; t++) begin
			wr(avs_pkg::REG_LOSS_CTL, {2'b00, t[1:0], 4'h5});
			chk("loss control", {4'h0, t[1:0], 2'b11}, {4'h0, thr, sq, det});
			chk("loss flags", 8'h05, {4'h0, flags});
		end
		rd(avs_pkg::REG_LOSS_STAT, 8'h05);
		lost <= 4'hf;
		repeat (10) @(posedge sys_clk);
		chk("loss flags", 8'h0f, {4'h0, flags});
		lost <= 4'h0;
		repeat (10) @(posedge sys_clk);
		chk("loss flags", 8'h00, {4'h0, flags});
		for (int i = 0; i < 6; i++) begin
			wr(avs_pkg::REG_HP_OVR, {4'h1, oh_tab[i]});
			chk("manual hotplug", {4'h0, oh_tab[i]}, {4'h0, hp_oe});
			chk("pin levels", 8'h00, {3'h0, sda_lvl, hp_lvl});
		end
		wr(avs_pkg::REG_HP_OVR, 8'h0f);
		chk("auto idle hotplug", 8'h00, {4'h0, hp_oe});
		wr(avs_pkg::REG_HP_WIDTH, 8'h03);
		chsw <= 1'b1;
		@(posedge sys_clk);
		chsw <= 1'b0;
		for (int k = 0; k < 8 && hp_oe !== 4'hf; k++) @(posedge sys_clk);
		cnt = 0;
		while (hp_oe === 4'hf && cnt < 200) begin
			@(posedge sys_clk);
			cnt++;
		end
		// One cycle of lag allowed
		if (cnt == 3 * STEP + 1) cnt = 3 * STEP;
		chk("pulse length", 8'(3 * STEP), 8'(cnt));
		wr(avs_pkg::REG_EDID_MODE, 8'h01);
		chk("replicator bypass", 8'h01, {7'h0, bypass});
		rd(avs_pkg::REG_EDID_MODE, 8'h00);
		wr(avs_pkg::REG_EDID_MODE, 8'h00);
		chk("replicator bypass", 8'h00, {7'h0, bypass});
		for (int i = 0; i < 4; i++) begin
			wr(avs_pkg::REG_UNLOCK, keys[i]);
			chk("eeprom unlock", {7'h0, keys[i] === 8'h96}, {7'h0, unlock});
		end
		rd(avs_pkg::REG_UNLOCK, 8'h00);
		wr(avs_pkg::REG_PART, 8'h00);
		rd(avs_pkg::REG_PART, PART);
		m.write_reg({avs_pkg::SLAVE_ADDR_HI, 2'b10}, avs_pkg::REG_AUX, 8'h04, ok);
		chk("foreign address ack", 8'h00, {7'h0, ok});
		chk("aux unchanged", 8'h03, {6'h0, ddc, cec});
		m.start_cond();
		m.put_byte({dev_addr, 1'b0}, ok);
		m.put_byte(avs_pkg::REG_HP_WIDTH, ok);
		m.start_cond();
		m.put_byte({dev_addr, 1'b1}, ok);
		chk("burst ack", 8'h01, {7'h0, ok});
		m.get_byte(1'b0, rdat);
		chk("burst first", 8'h03, rdat);
		m.get_byte(1'b1, rdat);
		chk("burst second", 8'h0f, rdat);
		m.stop_cond();
		m.start_cond();
		m.put_byte({dev_addr, 1'b0}, ok);
		m.put_byte(avs_pkg::REG_EDID_MODE, ok);
		m.put_byte(8'h01, ok);
		m.put_byte(8'h96, ok);
		m.stop_cond();
		repeat (8) @(posedge sys_clk);
		chk("burst write", 8'h03, {6'h0, bypass, unlock});
		strap <= 2'b10;
		repeat (8) @(posedge sys_clk);
		wr(avs_pkg::REG_AUX, 8'h05);
		chk("strap address", 8'h01, {6'h0, ddc, cec});
		wrap_up();
	end
endmodule : tb
`default_nettype wire
